// ===== ocdt_asserts.sv
// Checker for the compare unit register port and counter reads.
// Assumes CE is held high by the surroundings.
`timescale 1ns/100ps
module ocdt_asserts (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [6:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [15:0] RDATA,
  input wire logic [5:0] COMPARE_EVENT
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  function automatic logic [15:0] wm(input logic [2:0] i);
    wm = i == 3'h0 ? 16'h3F87 : i == 3'h1 ? ocdt_pkg::CON2_WMASK : 16'hFFFF;
  endfunction
  property flt_keep;
    logic [6:0] a;
    logic [2:0] f;
    (RD && ADDR[2:0] == 3'h0, a = ADDR) ##1 (1'b1, f = RDATA[6:4])
      ##[1:200] (RD && ADDR == a) |=> (RDATA[6:4] & f) == f;
  endproperty
  property cnt_step;
    logic [15:0] c;
    (RD && ADDR[2:0] == 3'h4 ##1 (RD && $stable(ADDR), c = RDATA)) |=>
      RDATA == c || RDATA == c + 16'h0001 || RDATA == 16'h0000;
  endproperty
  rd_idle_a: assert property (!RD |=> RDATA == 16'h0000)
    else $error("read data not zero without read");
  rd_unmap_a: assert property (
    RD && ADDR[6:3] > 4'h5 |=> RDATA == 16'h0000)
    else $error("unmapped module read not zero");
  rd_index_a: assert property (
    RD && ADDR[2:0] > 3'h4 |=> RDATA == 16'h0000)
    else $error("unmapped index read not zero");
  con1_top_a: assert property (
    RD && ADDR[2:0] == 3'h0 |=> RDATA[15:14] == 2'h0)
    else $error("control 1 top bits not zero");
  wr_back_a: assert property (WR && ADDR[2:0] < 3'h4 && ADDR[6:3] < 4'h6
    ##1 RD && $stable(ADDR) |=> (RDATA & wm($past(ADDR[2:0], 2)))
    == ($past(WDATA, 2) & wm($past(ADDR[2:0], 2))))
    else $error("register readback differs from write");
  con2_hold_a: assert property (RD && ADDR[2:0] == 3'h1
    ##1 RD && $stable(ADDR) |=> RDATA == $past(RDATA))
    else $error("control 2 changed without write");
  flt_sticky_a: assert property (flt_keep)
    else $error("fault status cleared");
  cnt_step_a: assert property (cnt_step)
    else $error("counter step wrong");
  ev_c: cover property (|COMPARE_EVENT);
  wr_rd_c: cover property (WR ##1 RD);
  cnt_c: cover property (RD && ADDR[2:0] == 3'h4 ##1 RD);
endmodule
bind ocdt_top ocdt_asserts ocdt_asserts_i (.CLK_SYS, .RST, .ADDR, .WDATA,
  .WR, .RD, .RDATA, .COMPARE_EVENT);

// ===== ocdt_channel.sv
// One output compare module: registers, counter, compare and output.
// Assumes clock, enable and sync inputs already synchronised by the top.
`timescale 1ns/100ps
module ocdt_channel (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic wr,
  input wire logic [2:0] addr,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata,
  input wire logic [5:0] tick,
  input wire logic [5:0] tb_on,
  input wire logic [31:0] sync_ev,
  input wire logic [2:0] fault,
  input wire logic idle,
  input wire logic odd,
  ocdt_link_if.low lo,
  ocdt_link_if.high hi,
  output logic event_out,
  output logic pin
);
  logic [15:0] con1, con2, pri, sec, cnt;
  logic [15:0] next_con1, next_con2, next_pri, next_sec, next_cnt;
  logic next_pin, next_event;
  ocdt_pkg::ocdt_state_type state, next_state;
  ocdt_pkg::ocdt_mode_type mode;
  logic [2:0] tsel;
  logic [4:0] ssel;
  logic casc, upper, adv, clk_en, sev, pm, sm, pmf, smf;
  assign mode = ocdt_pkg::ocdt_mode_type'(con1[2:0]);
  assign tsel = con1[ocdt_pkg::CON1_TSEL +: 3];
  assign ssel = con2[ocdt_pkg::CON2_SYNC +: 5];
  assign casc = con2[ocdt_pkg::CON2_CASC];
  assign upper = casc && !odd;
  assign sev = ssel != ocdt_pkg::SYNC_FREE && sync_ev[ssel];
  always_comb begin
    adv = 1'b0;
    clk_en = 1'b0;
    if (tsel == ocdt_pkg::TB_PERIPH) begin
      adv = 1'b1;
      clk_en = 1'b1;
    end else if (tsel <= ocdt_pkg::TB_TIMER1) begin
      adv = tick[tsel];
      clk_en = tb_on[tsel];
    end
    if (idle && con1[ocdt_pkg::CON1_IDLE]) begin
      adv = 1'b0;
    end
    if (upper) begin
      adv = hi.wrap && hi.step;
    end
  end
  assign pm = cnt == pri;
  assign sm = cnt == sec;
  assign pmf = upper ? 1'b0 : (casc ? pm && lo.pri_match : pm);
  assign smf = upper ? 1'b0 : (casc ? sm && lo.sec_match : sm);
  assign lo.wrap = cnt == 16'hFFFF;
  assign lo.step = adv && state == ocdt_pkg::OCDT_RUN;
  assign hi.pri_match = pm;
  assign hi.sec_match = sm;
  always_comb begin
    next_con1 = con1;
    next_con2 = con2;
    next_pri = pri;
    next_sec = sec;
    next_cnt = cnt;
    next_state = state;
    next_pin = pin;
    next_event = 1'b0;
    if (wr) begin
      case (addr)
        ocdt_pkg::REG_CON1: next_con1 = (wdata & ocdt_pkg::CON1_WMASK)
          | (con1 & ~ocdt_pkg::CON1_WMASK);
        ocdt_pkg::REG_CON2: next_con2 = wdata & ocdt_pkg::CON2_WMASK;
        ocdt_pkg::REG_PRI: next_pri = wdata;
        ocdt_pkg::REG_SEC: next_sec = wdata;
        ocdt_pkg::REG_CNT: next_cnt = wdata;
        default: next_con1 = con1;
      endcase
    end
    for (int f = 0; f < 3; f++) begin
      if (con1[ocdt_pkg::CON1_EFLT0 + f] && fault[f]) begin
        next_con1[ocdt_pkg::CON1_FST0 + f] = 1'b1;
      end
    end
    case (state)
      ocdt_pkg::OCDT_IDLE: begin
        next_pin = 1'b0;
        if (mode != ocdt_pkg::OCDT_OFF) begin
          next_state = ocdt_pkg::OCDT_ARMED;
        end
      end
      ocdt_pkg::OCDT_ARMED: begin
        if (ssel == ocdt_pkg::SYNC_FREE) begin
          next_state = ocdt_pkg::OCDT_RUN;
        end else if (!con2[ocdt_pkg::CON2_TRIG]) begin
          if (clk_en) begin
            next_state = ocdt_pkg::OCDT_RUN;
          end
        end else if (sev) begin
          next_state = ocdt_pkg::OCDT_RUN;
          next_con1[ocdt_pkg::CON1_TRGST] = 1'b1;
        end
      end
      ocdt_pkg::OCDT_RUN: begin
        if (adv) begin
          next_cnt = cnt + 16'h0001;
        end
        if (sev && !con2[ocdt_pkg::CON2_TRIG]) begin
          next_cnt = 16'h0000;
        end
        if (adv && (pmf || smf) && !upper) begin
          next_event = 1'b1;
          case (mode)
            ocdt_pkg::OCDT_HIGH: next_pin = 1'b1;
            ocdt_pkg::OCDT_LOW: next_pin = 1'b0;
            ocdt_pkg::OCDT_TOGGLE: next_pin = pmf ? !pin : pin;
            ocdt_pkg::OCDT_SINGLE: begin
              next_pin = pmf;
              if (smf) begin
                next_con1[2:0] = 3'h0;
              end
            end
            default: next_pin = pmf ? 1'b1 : (smf ? 1'b0 : pin);
          endcase
        end
        if (mode == ocdt_pkg::OCDT_OFF) begin
          next_state = ocdt_pkg::OCDT_IDLE;
          next_con1[ocdt_pkg::CON1_TRGST] = 1'b0;
        end
      end
      default: next_state = ocdt_pkg::OCDT_IDLE;
    endcase
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      con1 <= ocdt_pkg::CON1_RESET;
      con2 <= ocdt_pkg::CON2_RESET;
      pri <= 16'h0000;
      sec <= 16'h0000;
      cnt <= 16'h0000;
      state <= ocdt_pkg::OCDT_IDLE;
      pin <= 1'b0;
      event_out <= 1'b0;
    end else if (ce) begin
      con1 <= next_con1;
      con2 <= next_con2;
      pri <= next_pri;
      sec <= next_sec;
      cnt <= next_cnt;
      state <= next_state;
      pin <= next_pin;
      event_out <= next_event;
    end
  end
  always_comb begin
    case (addr)
      ocdt_pkg::REG_CON1: rdata = con1;
      ocdt_pkg::REG_CON2: rdata = con2;
      ocdt_pkg::REG_PRI: rdata = pri;
      ocdt_pkg::REG_SEC: rdata = sec;
      ocdt_pkg::REG_CNT: rdata = cnt;
      default: rdata = 16'h0000;
    endcase
  end
endmodule

// ===== ocdt_far.sv
// Far side model: timer tick sources and sync event sources.
// Assumes the bench raises fire for one cycle per sync pulse.
`timescale 1ns/100ps
module ocdt_far (
  input wire logic clk,
  input wire logic rst,
  input wire logic fire,
  input wire logic [4:0] src,
  output logic [5:0] tb_tick,
  output logic [5:0] tb_on,
  output logic [30:0] sync_event
);
  logic [1:0] div;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div <= 2'h0;
      tb_tick <= 6'h00;
      tb_on <= 6'h00;
      sync_event <= 31'h0;
    end else begin
      div <= div + 2'h1;
      // Timers tick every fourth cycle
      tb_tick <= {6{div == 2'h3}};
      tb_on <= 6'h3F;
      sync_event <= fire ? 31'h1 << (src - 5'h1) : 31'h0;
    end
  end
endmodule

// ===== ocdt_link_if.sv
// Interface carrying cascade signals between a module and its neighbour.
// Assumes one instance per adjacent pair.
`timescale 1ns/100ps
interface ocdt_link_if;
  logic wrap;
  logic step;
  logic pri_match;
  logic sec_match;
  modport low (output wrap, output step, input pri_match, input sec_match);
  modport high (input wrap, input step, output pri_match, output sec_match);
endinterface

// ===== ocdt_pkg.sv
// Package for the output compare unit with dedicated timers.
// Assumes a 16-bit register port with a 3-bit register index per module.
package ocdt_pkg;
  localparam int NUM_MOD = 6;
  localparam int NUM_CLK = 6;
  // Register indices within one module window
  localparam logic [2:0] REG_CON1 = 3'h0;
  localparam logic [2:0] REG_CON2 = 3'h1;
  localparam logic [2:0] REG_PRI = 3'h2;
  localparam logic [2:0] REG_SEC = 3'h3;
  localparam logic [2:0] REG_CNT = 3'h4;
  // Control register 1 fields
  localparam int CON1_IDLE = 13;
  localparam int CON1_TSEL = 10;
  localparam int CON1_EFLT2 = 9;
  localparam int CON1_EFLT1 = 8;
  localparam int CON1_EFLT0 = 7;
  localparam int CON1_FST2 = 6;
  localparam int CON1_FST1 = 5;
  localparam int CON1_FST0 = 4;
  localparam int CON1_TRGST = 3;
  localparam int CON1_MODE = 0;
  localparam logic [15:0] CON1_WMASK = 16'h3F87;
  localparam logic [15:0] CON1_RESET = 16'h0000;
  // Control register 2 fields
  localparam int CON2_CASC = 8;
  localparam int CON2_TRIG = 7;
  localparam int CON2_SYNC = 0;
  localparam logic [15:0] CON2_WMASK = 16'h019F;
  localparam logic [15:0] CON2_RESET = 16'h0000;
  localparam logic [4:0] SYNC_FREE = 5'h00;
  // Timebase codes
  localparam logic [2:0] TB_PERIPH = 3'h7;
  localparam logic [2:0] TB_TIMER1 = 3'h4;
  // Compare modes
  typedef enum logic [2:0] {
    OCDT_OFF = 3'h0, OCDT_HIGH = 3'h1, OCDT_LOW = 3'h2, OCDT_TOGGLE = 3'h3,
    OCDT_SINGLE = 3'h4, OCDT_CONT = 3'h5, OCDT_EDGE_PWM = 3'h6,
    OCDT_CTR_PWM = 3'h7
  } ocdt_mode_type;
  // Run state per module, Gray ordered
  typedef enum logic [1:0] {
    OCDT_IDLE = 2'b00, OCDT_ARMED = 2'b01, OCDT_RUN = 2'b11
  } ocdt_state_type;
endpackage

// ===== ocdt_top.sv
// Top of the six-module output compare unit with dedicated timers.
// Assumes timebase ticks and sync events come from other clock logic.
//
// Summary of operation
// - Six independent compare modules, each with counter and two periods.
// - Free-running counter counts up and wraps FFFF to 0000.
// - Counter advances only on the selected timebase tick; a cascaded high half advances only on low half wrap.
// - Event when counter equals primary or secondary period at a count step; never from a cascaded high half.
// - Primary and secondary period registers per module.
// - Single pulse, continuous pulse and PWM output modes.
// - Counter clock chosen among six timebases.
// - Synchronous mode starts once the selected timebase is enabled.
// - Synchronous mode clears counter on each sync source event.
// - Trigger mode holds counter until a sync event arrives.
// - Sync select zero means free-running, also the reset default.
// - Nonzero sync select picks sync or trigger and its source.
// - Up to 31 sync or trigger sources are selectable.
// - Control 2 bit 7 set selects trigger, clear selects sync.
// - Odd/even pairs may cascade into one 32-bit module.
// - Odd module holds low half, even module holds high half.
// - Low half wrap increments the high half.
// - Timebase codes 0-3 timers two to five, 4 timer one, 7 peripheral.
`timescale 1ns/100ps
module ocdt_top (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic CE,
  input wire logic [6:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  input wire logic [5:0] TB_TICK,
  input wire logic [5:0] TB_ON,
  input wire logic [30:0] SYNC_EVENT,
  input wire logic [5:0][2:0] FAULT_IN,
  input wire logic IDLE,
  output logic [5:0] COMPARE_EVENT,
  output logic [5:0] COMPARE_OUT
);
  logic [5:0] tick_s1, tick_s2, on_s1, on_s2, ev_out, pin_out;
  logic [30:0] sync_s1, sync_s2;
  logic [17:0] flt_s1, flt_s2;
  logic idle_s1, idle_s2;
  logic [31:0] sync_vec;
  logic [15:0] rd_mux [6];
  logic [15:0] next_rdata;
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      tick_s1 <= 6'h00;
      tick_s2 <= 6'h00;
      on_s1 <= 6'h00;
      on_s2 <= 6'h00;
      sync_s1 <= 31'h00000000;
      sync_s2 <= 31'h00000000;
      flt_s1 <= 18'h00000;
      flt_s2 <= 18'h00000;
      idle_s1 <= 1'b0;
      idle_s2 <= 1'b0;
    end else if (CE) begin
      tick_s1 <= TB_TICK;
      tick_s2 <= tick_s1;
      on_s1 <= TB_ON;
      on_s2 <= on_s1;
      sync_s1 <= SYNC_EVENT;
      sync_s2 <= sync_s1;
      flt_s1 <= FAULT_IN;
      flt_s2 <= flt_s1;
      idle_s1 <= IDLE;
      idle_s2 <= idle_s1;
    end
  end
  assign sync_vec = {sync_s2, 1'b0};
  ocdt_link_if link [3] ();
  ocdt_link_if tie [3] ();
  genvar g;
  generate
    for (g = 0; g < ocdt_pkg::NUM_MOD; g++) begin : g_mod
      if (g % 2 == 0) begin : g_low
        ocdt_channel u_ch (
          .clk(CLK_SYS), .rst(RST), .ce(CE),
          .wr(WR && ADDR[6:3] == 4'(g)), .addr(ADDR[2:0]), .wdata(WDATA),
          .rdata(rd_mux[g]), .tick(tick_s2), .tb_on(on_s2),
          .sync_ev(sync_vec), .fault(flt_s2[3 * g +: 3]), .idle(idle_s2),
          .odd(1'b1), .lo(link[g / 2]), .hi(tie[g / 2]),
          .event_out(ev_out[g]), .pin(pin_out[g])
        );
      end else begin : g_high
        ocdt_channel u_ch (
          .clk(CLK_SYS), .rst(RST), .ce(CE),
          .wr(WR && ADDR[6:3] == 4'(g)), .addr(ADDR[2:0]), .wdata(WDATA),
          .rdata(rd_mux[g]), .tick(tick_s2), .tb_on(on_s2),
          .sync_ev(sync_vec), .fault(flt_s2[3 * g +: 3]), .idle(idle_s2),
          .odd(1'b0), .lo(tie[g / 2]), .hi(link[g / 2]),
          .event_out(ev_out[g]), .pin(pin_out[g])
        );
      end
    end
  endgenerate
  always_comb begin
    next_rdata = 16'h0000;
    if (RD && ADDR[6:3] < 4'(ocdt_pkg::NUM_MOD)) begin
      next_rdata = rd_mux[ADDR[5:3]];
    end
  end
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      RDATA <= 16'h0000;
      COMPARE_EVENT <= 6'h00;
      COMPARE_OUT <= 6'h00;
    end else if (CE) begin
      RDATA <= next_rdata;
      COMPARE_EVENT <= ev_out;
      COMPARE_OUT <= pin_out;
    end
  end
endmodule

// ===== testbench.sv
// Self-checking bench for the compare unit.
// Assumes the far side model supplies ticks and sync pulses.
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [6:0] addr = 7'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic fire = 1'b0;
  logic [4:0] src = 5'h01;
  logic [5:0][2:0] fault = 18'h0;
  logic [15:0] rdata, v1, v2, v3;
  logic [5:0] tick, ton, ev, pin;
  logic [30:0] sev;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  always #10 clk = ~clk;
  ocdt_far ocdt_far_i (.clk(clk), .rst(rst), .fire(fire), .src(src),
    .tb_tick(tick), .tb_on(ton), .sync_event(sev));
  ocdt_top ocdt_top_i (.CLK_SYS(clk), .RST(rst), .CE(1'b1), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .TB_TICK(tick),
    .TB_ON(ton), .SYNC_EVENT(sev), .FAULT_IN(fault), .IDLE(1'b0),
    .COMPARE_EVENT(ev), .COMPARE_OUT(pin));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      report_and_stop();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [6:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Two back-to-back reads of one address
  task automatic rd2(input logic [6:0] a, output logic [15:0] d1,
    output logic [15:0] d2);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    d1 = rdata;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d2 = rdata;
  endtask
  task automatic chk(input logic [6:0] a, input logic [15:0] exp);
    rd2(a, v1, v2);
    check(v1, exp);
  endtask
  // Write, then read the same register in the very next cycle
  task automatic wr_rd(input logic [6:0] a, input logic [15:0] d,
    output logic [15:0] q);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    q = rdata;
  endtask
  task automatic wait_ev(input int m);
    int n = 0;
    while (ev[m] !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    check({15'h0, ev[m]}, 16'h0001);
    repeat (3) @(negedge clk);
  endtask
  task automatic pulse();
    @(posedge clk);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int m = 0; m < 6; m++) begin
      chk({m[3:0], 3'h0}, 16'h0000);
      chk({m[3:0], 3'h1}, 16'h0000);
    end
    wr_rd(7'h08, 16'hFFFF, v1);
    check(v1, 16'h3F87);
    wr_rd(7'h09, 16'hFFFF, v1);
    check(v1, 16'h019F);
    wreg(7'h09, 16'h0000);
    wreg(7'h08, 16'h0005);
    rd2(7'h0C, v1, v2);
    repeat (5) @(posedge clk);
    rd2(7'h0C, v3, v2);
    check(v3, v1 + 16'h0002);
    wr_rd(7'h30, 16'hFFFF, v1);
    check(v1, 16'h0000);
    wr_rd(7'h05, 16'hFFFF, v1);
    check(v1, 16'h0000);
    wr_rd(7'h02, 16'h0010, v1);
    check(v1, 16'h0010);
    wr_rd(7'h03, 16'h0020, v1);
    check(v1, 16'h0020);
    wreg(7'h00, 16'h1C05);
    repeat (4) @(posedge clk);
    rd2(7'h04, v1, v2);
    check(v2, v1 + 16'h0001);
    wreg(7'h01, 16'h0001);
    pulse();
    repeat (6) @(posedge clk);
    rd2(7'h04, v1, v2);
    check({15'h0, v1 < 16'h0010}, 16'h0001);
    wait_ev(0);
    check({15'h0, pin[0]}, 16'h0001);
    wait_ev(0);
    check({15'h0, pin[0]}, 16'h0000);
    wreg(7'h12, 16'h0010);
    wreg(7'h11, 16'h0082);
    wreg(7'h10, 16'h1C05);
    src <= 5'h02;
    repeat (4) @(posedge clk);
    rd2(7'h14, v1, v2);
    check(v2, v1);
    pulse();
    repeat (6) @(posedge clk);
    rd2(7'h14, v1, v2);
    check(v2, v1 + 16'h0001);
    wreg(7'h18, 16'h0380);
    @(posedge clk);
    fault[3] <= 3'h7;
    repeat (2) @(posedge clk);
    fault[3] <= 3'h0;
    repeat (4) @(posedge clk);
    chk(7'h18, 16'h03F0);
    wreg(7'h18, 16'h0380);
    chk(7'h18, 16'h03F0);
    wreg(7'h1A, 16'h0004);
    wreg(7'h1B, 16'h0008);
    wreg(7'h18, 16'h1F84);
    repeat (20) @(posedge clk);
    chk(7'h18, 16'h1FF0);
    wreg(7'h21, 16'h0100);
    wreg(7'h29, 16'h0100);
    chk(7'h21, 16'h0100);
    chk(7'h29, 16'h0100);
    wreg(7'h28, 16'h1C05);
    wreg(7'h24, 16'hFFF0);
    wreg(7'h20, 16'h1C05);
    repeat (30) @(posedge clk);
    rd2(7'h2C, v1, v2);
    check(v1, 16'h0001);
    rd2(7'h24, v1, v2);
    check({15'h0, v1 < 16'h0040}, 16'h0001);
    report_and_stop();
  end
endmodule
